//--- rtl/embp_pkg.sv
// constants and types for the external memory bus port
`default_nettype none
package embp_pkg;
  // ****************************************************
  // bus geometry
  // ****************************************************
  localparam int unsigned EMBP_NUM_CS = 7;
  localparam int unsigned EMBP_ADDR_W = 10;
  localparam int unsigned EMBP_DATA_W = 16;
  localparam int unsigned EMBP_LANE_W = 2;
  localparam int unsigned EMBP_WS_W = 4;
  localparam int unsigned EMBP_DIV_W = 4;
  localparam int unsigned EMBP_CS_IDX_W = 3;
  // chip select zero belongs to the boot flash
  localparam logic [EMBP_CS_IDX_W-1:0] EMBP_CS_FLASH = 3'h0;
  localparam logic [EMBP_CS_IDX_W-1:0] EMBP_CS_NONE = 3'h7;
  // ****************************************************
  // reset values and counts
  // ****************************************************
  localparam logic [EMBP_CS_IDX_W-1:0] EMBP_CS_ALL_N = 3'h0;
  localparam logic [EMBP_NUM_CS-1:0] EMBP_CS_IDLE = 7'h7f;
  localparam logic [EMBP_LANE_W-1:0] EMBP_LANE_IDLE = 2'h3;
  localparam logic [EMBP_WS_W-1:0] EMBP_WS_ZERO = 4'h0;
  localparam logic [EMBP_DIV_W-1:0] EMBP_DIV_ZERO = 4'h0;
  localparam logic [EMBP_ADDR_W-1:0] EMBP_ADDR_ZERO = 10'h000;
  localparam logic [EMBP_DATA_W-1:0] EMBP_DATA_ZERO = 16'h0000;
  typedef enum logic [2:0] {
    EMBP_IDLE,
    EMBP_ADDR,
    EMBP_WAIT,
    EMBP_STALL,
    EMBP_DONE
  } embp_state_t;
endpackage : embp_pkg
`default_nettype wire

//--- rtl/embp_port.sv
// external memory bus port: controller request side and connector pin side
`default_nettype none
module embp_port
  import embp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic bus_clock_i,
  input wire logic bus_rst_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [EMBP_ADDR_W-1:0] req_addr_i,
  input wire logic [EMBP_DATA_W-1:0] req_wdata_i,
  input wire logic [EMBP_LANE_W-1:0] req_lanes_i,
  input wire logic [EMBP_NUM_CS*EMBP_ADDR_W-1:0] cs_base_i,
  input wire logic [EMBP_NUM_CS*EMBP_ADDR_W-1:0] cs_mask_i,
  input wire logic [EMBP_NUM_CS-1:0] cs_enable_i,
  input wire logic [EMBP_WS_W-1:0] wait_states_i,
  input wire logic [EMBP_DIV_W-1:0] clk_div_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [EMBP_DATA_W-1:0] resp_rdata_o,
  output logic resp_miss_o,
  output logic flash_boot_select_n_o,
  output logic [EMBP_NUM_CS-2:0] ext_select_n_o,
  output logic write_strobe_n_o,
  output logic read_enable_n_o,
  output logic addr_valid_latch_n_o,
  output logic low_byte_lane_n_o,
  output logic high_byte_lane_n_o,
  output logic bus_clk_o,
  output logic [EMBP_ADDR_W-1:0] bus_addr_bit_o,
  input wire logic [EMBP_DATA_W-1:0] bus_data_bit_i,
  output logic [EMBP_DATA_W-1:0] bus_data_bit_o,
  output logic bus_data_oe_n_o,
  output logic buffer_direction_o,
  input wire logic stall_in_n_i,
  input wire logic ext_dma_request_i,
  output logic dma_request_line1_n_o
);
  // ****************************************************
  // chip select decode
  // ****************************************************
  function automatic logic [EMBP_CS_IDX_W-1:0] cs_lookup(
    input logic [EMBP_ADDR_W-1:0] addr,
    input logic [EMBP_NUM_CS*EMBP_ADDR_W-1:0] base,
    input logic [EMBP_NUM_CS*EMBP_ADDR_W-1:0] mask,
    input logic [EMBP_NUM_CS-1:0] en
  );
    logic [EMBP_CS_IDX_W-1:0] hit;
    hit = EMBP_CS_NONE;
    for (int i = EMBP_NUM_CS - 1; i >= 0; i--) begin
      if (en[i] && ((addr & mask[i*EMBP_ADDR_W +: EMBP_ADDR_W]) ==
          (base[i*EMBP_ADDR_W +: EMBP_ADDR_W] & mask[i*EMBP_ADDR_W +: EMBP_ADDR_W]))) begin
        hit = EMBP_CS_IDX_W'(i);
      end
    end
    return hit;
  endfunction

  // lowest matching window wins, so overlapping windows never select two
  wire logic [EMBP_CS_IDX_W-1:0] req_cs = cs_lookup(req_addr_i, cs_base_i, cs_mask_i,
                                                   cs_enable_i);
  wire logic req_hit = (req_cs != EMBP_CS_NONE);

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic stall_n_sync;
  logic dreq_sync;
  logic [EMBP_DATA_W-1:0] data_sync;

  embp_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_stall_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(stall_in_n_i),
    .sync_o(stall_n_sync)
  );

  embp_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_dreq_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_dma_request_i),
    .sync_o(dreq_sync)
  );

  embp_sync #(.WIDTH(EMBP_DATA_W), .RESET_VAL(EMBP_DATA_ZERO)) u_data_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(bus_data_bit_i),
    .sync_o(data_sync)
  );

  // ****************************************************
  // transfer sequencer
  // ****************************************************
  embp_state_t state;
  embp_state_t next_state;
  logic [EMBP_WS_W-1:0] ws_cnt;
  logic [EMBP_CS_IDX_W-1:0] cur_cs;
  logic cur_write;

  wire logic ws_done = (ws_cnt == EMBP_WS_ZERO);
  wire logic take_req = (state == EMBP_IDLE) && req_valid_i;
  wire logic in_xfer = (state == EMBP_ADDR) || (state == EMBP_WAIT) ||
                       (state == EMBP_STALL);

  always_comb begin
    next_state = state;
    case (state)
      EMBP_IDLE: begin
        if (req_valid_i && req_hit) begin
          next_state = EMBP_ADDR;
        end
      end
      EMBP_ADDR: begin
        next_state = EMBP_WAIT;
      end
      EMBP_WAIT: begin
        if (ws_done) begin
          next_state = stall_n_sync ? EMBP_DONE : EMBP_STALL;
        end
      end
      EMBP_STALL: begin
        if (stall_n_sync) begin
          next_state = EMBP_DONE;
        end
      end
      EMBP_DONE: begin
        next_state = EMBP_IDLE;
      end
      default: begin
        next_state = EMBP_IDLE;
      end
    endcase
  end

  wire logic [EMBP_WS_W-1:0] next_ws_cnt =
    (state == EMBP_ADDR) ? wait_states_i :
    ((state == EMBP_WAIT) && !ws_done) ? ws_cnt - 1'b1 : ws_cnt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= EMBP_IDLE;
      ws_cnt <= EMBP_WS_ZERO;
      cur_cs <= EMBP_CS_NONE;
      cur_write <= 1'b0;
    end else begin
      state <= next_state;
      ws_cnt <= next_ws_cnt;
      cur_cs <= take_req ? req_cs : ((next_state == EMBP_IDLE) ? EMBP_CS_NONE : cur_cs);
      cur_write <= take_req ? req_write_i : cur_write;
    end
  end

  // ****************************************************
  // pin drive
  // ****************************************************
  logic [EMBP_NUM_CS-1:0] cs_n;
  logic [EMBP_NUM_CS-1:0] next_cs_n;
  always_comb begin
    next_cs_n = EMBP_CS_IDLE;
    if ((next_state != EMBP_IDLE) && (next_state != EMBP_DONE)) begin
      next_cs_n[take_req ? req_cs : cur_cs] = 1'b0;
    end
  end

  wire logic next_active = (next_state == EMBP_ADDR) || (next_state == EMBP_WAIT) ||
                           (next_state == EMBP_STALL);
  wire logic next_wr = take_req ? req_write_i : cur_write;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n <= EMBP_CS_IDLE;
      write_strobe_n_o <= 1'b1;
      read_enable_n_o <= 1'b1;
      addr_valid_latch_n_o <= 1'b1;
      low_byte_lane_n_o <= 1'b1;
      high_byte_lane_n_o <= 1'b1;
      bus_addr_bit_o <= EMBP_ADDR_ZERO;
      bus_data_bit_o <= EMBP_DATA_ZERO;
      bus_data_oe_n_o <= 1'b1;
      buffer_direction_o <= 1'b1;
    end else begin
      cs_n <= next_cs_n;
      write_strobe_n_o <= !(next_active && next_wr);
      read_enable_n_o <= !(next_active && !next_wr);
      addr_valid_latch_n_o <= !(next_state == EMBP_ADDR);
      if (take_req) begin
        bus_addr_bit_o <= req_addr_i;
        bus_data_bit_o <= req_wdata_i;
        low_byte_lane_n_o <= !req_lanes_i[0];
        high_byte_lane_n_o <= !req_lanes_i[1];
      end else if (!next_active) begin
        low_byte_lane_n_o <= 1'b1;
        high_byte_lane_n_o <= 1'b1;
      end
      bus_data_oe_n_o <= !(next_active && next_wr);
      buffer_direction_o <= !(next_active && next_wr);
    end
  end

  assign flash_boot_select_n_o = cs_n[EMBP_CS_FLASH];
  assign ext_select_n_o = cs_n[EMBP_NUM_CS-1:1];

  // ****************************************************
  // controller answer
  // ****************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ready_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_rdata_o <= EMBP_DATA_ZERO;
      resp_miss_o <= 1'b0;
      dma_request_line1_n_o <= 1'b1;
    end else begin
      req_ready_o <= (next_state == EMBP_IDLE) && !take_req;
      resp_valid_o <= (state == EMBP_DONE) || (take_req && !req_hit);
      resp_miss_o <= take_req && !req_hit;
      // read data needs one wait state to clear the pin synchroniser
      if ((next_state == EMBP_DONE) && !cur_write) begin
        resp_rdata_o <= data_sync;
      end
      dma_request_line1_n_o <= !dreq_sync;
    end
  end

  // ****************************************************
  // bus clock domain
  // ****************************************************
  // run flag crosses as a level; divider runs on the bus clock source
  logic run_meta;
  logic run_sync;
  logic [EMBP_DIV_W-1:0] div_cnt;
  logic bclk;
  always_ff @(posedge bus_clock_i or negedge bus_rst_n_i) begin
    if (!bus_rst_n_i) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
    end else begin
      run_meta <= in_xfer;
      run_sync <= run_meta;
    end
  end

  // divider setting is only taken while the bus clock is parked
  logic [EMBP_DIV_W-1:0] div_q;
  always_ff @(posedge bus_clock_i or negedge bus_rst_n_i) begin
    if (!bus_rst_n_i) begin
      div_q <= EMBP_DIV_ZERO;
    end else if (!run_sync) begin
      div_q <= clk_div_i;
    end
  end

  wire logic div_hit = (div_cnt == div_q);
  always_ff @(posedge bus_clock_i or negedge bus_rst_n_i) begin
    if (!bus_rst_n_i) begin
      div_cnt <= EMBP_DIV_ZERO;
      bclk <= 1'b0;
    end else if (!run_sync) begin
      div_cnt <= EMBP_DIV_ZERO;
      bclk <= 1'b0;
    end else begin
      div_cnt <= div_hit ? EMBP_DIV_ZERO : div_cnt + 1'b1;
      bclk <= div_hit ? !bclk : bclk;
    end
  end
  assign bus_clk_o = bclk;

  // ****************************************************
  // checks
  // ****************************************************
  // two clock domains here, so every check names its own clock
  one_select_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $onehot0(~cs_n))
    else $error("more than one chip select low");
  idle_select_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_IDLE) |-> (cs_n == EMBP_CS_IDLE))
    else $error("chip select low outside a transfer");
  write_strobe_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !write_strobe_n_o |-> read_enable_n_o)
    else $error("write and read strobes low together");
  read_strobe_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_WAIT && !cur_write) |-> !read_enable_n_o)
    else $error("read enable high during a read");
  addr_phase_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(state == EMBP_ADDR) |-> !addr_valid_latch_n_o ##1 addr_valid_latch_n_o)
    else $error("address valid not a single cycle");
  stall_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_STALL && !stall_n_sync) |=> state == EMBP_STALL)
    else $error("transfer ended while stalled");
  wait_len_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_ADDR && wait_states_i == 4'h2) |=> (state == EMBP_WAIT) [*3])
    else $error("wrong wait state count");
  dir_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !write_strobe_n_o |-> !buffer_direction_o && !bus_data_oe_n_o)
    else $error("direction wrong on write");
  dma_pass_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      dreq_sync |=> !dma_request_line1_n_o)
    else $error("dma request not forwarded");
  lane_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (take_req && req_hit && req_lanes_i[0]) |=> !low_byte_lane_n_o)
    else $error("low lane not enabled");
  lane_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (take_req && req_hit && req_lanes_i[1]) |=> !high_byte_lane_n_o)
    else $error("high lane not enabled");
  addr_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_WAIT) |-> $stable(bus_addr_bit_o))
    else $error("address pins moved during a transfer");
  data_drive_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == EMBP_WAIT && cur_write) |-> !bus_data_oe_n_o)
    else $error("write data not driven");
  clk_idle_a: assert property (@(posedge bus_clock_i) disable iff (!bus_rst_n_i)
      !run_sync |=> !bclk)
    else $error("bus clock runs outside a transfer");

  flash_cov: cover property (@(posedge clock_i) !flash_boot_select_n_o);
  stall_cov: cover property (@(posedge clock_i) state == EMBP_STALL ##1 state == EMBP_DONE);
  write_cov: cover property (@(posedge clock_i) !write_strobe_n_o && !ext_select_n_o[0]);
  miss_cov: cover property (@(posedge clock_i) resp_miss_o);
endmodule : embp_port
`default_nettype wire

//--- rtl/embp_sync.sv
// two flip-flop level synchroniser
`default_nettype none
module embp_sync
  import embp_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : embp_sync
`default_nettype wire

//--- testbench/embp_ext_dev.sv
// off-board memory device model on the parallel bus
`default_nettype none
module embp_ext_dev
  import embp_pkg::*;
(
  input wire logic clock_i,
  input wire logic [EMBP_NUM_CS-1:0] select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_enable_n_i,
  input wire logic low_byte_lane_n_i,
  input wire logic high_byte_lane_n_i,
  input wire logic [EMBP_ADDR_W-1:0] addr_i,
  input wire logic [EMBP_DATA_W-1:0] data_i,
  input wire logic data_oe_n_i,
  input wire logic direction_i,
  input wire logic [7:0] stall_len_i,
  output logic [EMBP_DATA_W-1:0] data_o,
  output logic stall_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [EMBP_DATA_W-1:0] mem [0:1023];
  logic [EMBP_DATA_W-1:0] last = '0;
  logic [7:0] stall_cnt = '0;
  logic sel_q = 1'b0;
  wire logic sel = (select_n_i != EMBP_CS_IDLE);
  wire logic drive = sel && !read_enable_n_i && direction_i;
  initial begin
    for (int i = 0; i < 1024; i++)
      mem[i] = '0;
  end
  // ****************************************************
  // stall, write capture, read drive
  // ****************************************************
  always @(posedge clock_i) begin
    sel_q <= sel;
    if (sel && !sel_q)
      stall_cnt <= stall_len_i;
    else if (stall_cnt != 8'h00)
      stall_cnt <= stall_cnt - 8'h01;
    if (sel && !write_strobe_n_i && !data_oe_n_i) begin
      if (!low_byte_lane_n_i)
        mem[addr_i][7:0] <= data_i[7:0];
      if (!high_byte_lane_n_i)
        mem[addr_i][15:8] <= data_i[15:8];
    end
    if (drive)
      last <= mem[addr_i];
  end
  assign stall_n_o = (stall_cnt == 8'h00);
  // released lines show the inverse of the last value
  assign data_o = drive ? mem[addr_i] : ~last;
endmodule // embp_ext_dev
`default_nettype wire

//--- testbench/external_memory_bus_port_tb.sv
// self-checking bench for the external memory bus port
`default_nettype none
module external_memory_bus_port_tb
  import embp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, bclk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0;
  logic dma = 1'b0;
  logic [9:0] addr = '0;
  logic [15:0] wdata = '0;
  logic [1:0] lanes = 2'h3;
  logic [69:0] base = '0, mask = '0;
  logic [6:0] en = 7'h7f;
  logic [3:0] ws = 4'h2, div = 4'h0;
  logic [7:0] stall = '0;
  wire logic [6:0] sel_n;
  wire logic [15:0] rdata, pin_wd, pin_rd;
  wire logic [9:0] pin_a;
  wire logic stall_n, ready, rvalid, miss, we_n, oe_n, adv_n, lo_n, hi_n;
  wire logic bus_clk, doe_n, dir, dreq_n;
  int mismatches = 0, compares = 0, cyc = 0, seen_cs = 7, rises = 0;
  logic seen_we, seen_oe, seen_adv, seen_dir, bclk_q = 1'b0;
  logic [1:0] seen_ln;
  logic [9:0] seen_a;
  logic [15:0] shadow [0:1023];
  always #5 clk = ~clk;
  initial #3 forever #15 bclk = ~bclk;
  embp_port u_dut (
    .clock_i(clk), .rst_n_i(rst_n), .bus_clock_i(bclk), .bus_rst_n_i(rst_n),
    .req_valid_i(valid), .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wdata),
    .req_lanes_i(lanes), .cs_base_i(base), .cs_mask_i(mask), .cs_enable_i(en),
    .wait_states_i(ws), .clk_div_i(div), .req_ready_o(ready), .resp_valid_o(rvalid),
    .resp_rdata_o(rdata), .resp_miss_o(miss), .flash_boot_select_n_o(sel_n[0]),
    .ext_select_n_o(sel_n[6:1]), .write_strobe_n_o(we_n), .read_enable_n_o(oe_n),
    .addr_valid_latch_n_o(adv_n), .low_byte_lane_n_o(lo_n), .high_byte_lane_n_o(hi_n),
    .bus_clk_o(bus_clk), .bus_addr_bit_o(pin_a), .bus_data_bit_i(pin_rd),
    .bus_data_bit_o(pin_wd), .bus_data_oe_n_o(doe_n), .buffer_direction_o(dir),
    .stall_in_n_i(stall_n), .ext_dma_request_i(dma), .dma_request_line1_n_o(dreq_n)
  );
  embp_ext_dev u_dev (
    .clock_i(clk), .select_n_i(sel_n), .write_strobe_n_i(we_n), .read_enable_n_i(oe_n),
    .low_byte_lane_n_i(lo_n), .high_byte_lane_n_i(hi_n), .addr_i(pin_a),
    .data_i(pin_wd), .data_oe_n_i(doe_n), .direction_i(dir), .stall_len_i(stall),
    .data_o(pin_rd), .stall_n_o(stall_n)
  );
  // ****************************************************
  // checking and closing
  // ****************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic int exp_cs(input logic [9:0] a);
    for (int i = 0; i < 7; i++)
      if (en[i] && ((a & mask[i*10+:10]) == (base[i*10+:10] & mask[i*10+:10])))
        return i;
    return 7;
  endfunction
  // stall pin passes two flops before the sequencer sees it
  function automatic int exp_lat(input int w, input int s);
    if (s != 0 && w <= s + 1)
      return s + 5;
    return w + 3;
  endfunction
  // ****************************************************
  // pin monitor and cycle limit
  // ****************************************************
  always @(negedge clk) begin
    cyc++;
    bclk_q <= bus_clk;
    if (bus_clk && !bclk_q)
      rises++;
    check({15'h0, $countones(~sel_n) > 1}, 16'h0, "two selects");
    if (sel_n !== EMBP_CS_IDLE) begin
      for (int i = 0; i < 7; i++)
        if (!sel_n[i])
          seen_cs = i;
      seen_we |= !we_n;
      seen_oe |= !oe_n;
      seen_adv |= !adv_n;
      if (!we_n || !oe_n)
        seen_dir = dir;
      seen_ln = {hi_n, lo_n};
      seen_a = pin_a;
    end
    if (cyc == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic xfer(input logic w, input logic [9:0] a);
    int n;
    int c;
    c = exp_cs(a);
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    valid = 1'b1;
    wr = w;
    addr = a;
    {seen_cs, seen_we, seen_oe, seen_adv, seen_dir, rises} = {32'd7, 4'h0, 32'd0};
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(16'(miss), 16'(c == 7), "miss flag");
    check(16'(ready), 16'(c != 7), "ready after answer");
    if (c == 7)
      check(16'(n), 16'h0, "miss latency");
    else begin
      check(16'(seen_cs), 16'(c), "select");
      check({12'h0, seen_we, seen_oe, seen_dir, seen_adv}, {12'h0, w, !w, !w, 1'b1},
        "strobes");
      check(16'(seen_ln), {14'h0, ~lanes}, "lanes");
      check(16'(seen_a), 16'(a), "address");
      if (stall == 8'h00)
        check(16'(n), 16'(3 + ws), "latency");
      else
        check(16'(n), 16'(exp_lat(ws, stall)), "stall stretch");
      if (n > 40)
        check(16'(rises > 0), 16'h1, "bus clock");
      if (w && lanes[0])
        shadow[a][7:0] = wdata[7:0];
      if (w && lanes[1])
        shadow[a][15:8] = wdata[15:8];
      if (!w)
        check(rdata, shadow[a], "read data");
    end
    check({9'h0, sel_n}, 16'h7f, "selects idle");
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(52));
    for (int i = 0; i < 1024; i++)
      shadow[i] = '0;
    for (int i = 0; i < 7; i++) begin
      base[i*10+:10] = 10'(i << 7);
      mask[i*10+:10] = 10'h380;
    end
    repeat (20) @(negedge clk);
    check({9'h0, sel_n}, 16'h7f, "reset selects");
    check({11'h0, dir, we_n, oe_n, adv_n, doe_n}, 16'h1f, "reset strobes");
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    // every window and a miss, long flash-style stall, dividers 0 to 3
    for (int i = 0; i < 8; i++) begin
      {stall, ws, div, lanes} = {8'h28, 4'hf, 4'(i % 4), 2'(i % 3 + 1)};
      wdata = 16'($urandom);
      xfer(1'b1, 10'((i << 7) | 5));
      xfer(1'b0, 10'((i << 7) | 5));
    end
    repeat (30) @(negedge clk);
    check(16'(bus_clk), 16'h0, "bus clock idle");
    dma = 1'b1;
    repeat (4) @(negedge clk);
    check(16'(dreq_n), 16'h0, "dma request");
    dma = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(dreq_n), 16'h1, "dma release");
    for (int k = 0; k < 200; k++) begin
      if (k == 100) begin
        for (int i = 0; i < 7; i++)
          base[i*10+:10] = 10'((6 - i) << 7);
        en = 7'h77;
      end
      ws = 4'($urandom_range(15, 2));
      div = 4'($urandom_range(3, 0));
      stall = 8'($urandom_range(3, 0) == 0 ? $urandom_range(12, 1) : 0);
      lanes = 2'($urandom_range(3, 1));
      wdata = 16'($urandom);
      addr = 10'($urandom);
      xfer(1'b1, addr);
      lanes = 2'($urandom_range(3, 1));
      xfer(1'b0, addr);
    end
    report_and_stop();
  end
endmodule // external_memory_bus_port_tb
`default_nettype wire
